// file: design/asm_pkg.sv
// Purpose: constants and types for the ALU, its flags register and the 8x8 multiplier
// Assumes: one operation per enabled clock, issued by the core's execution unit
// Notes: addresses are file-register addresses on the core's data side
//
// Contract
// - flags register holds ALU status flags and the two pointer step-mode fields
// - any operation except multiply may name the flags register as its destination
// - flag-affecting op to flags register: zero, half-carry, carry come from the ALU
// - clear aimed at flags register zeroes upper nibble, sets zero, keeps carries
// - subtraction drives carry and half-carry as inverted borrow indicators
// - signed range flag sets when two's complement result leaves -128..+127
// - single-operand ops act on the working accumulator or the addressed file register
// - two-operand ops take the accumulator and a file register or 8-bit immediate
// - multiplier forms 16-bit product into low and high result registers 18h, 19h
// - flags register at 04h; upper four bits reset to one, low four flags
// - addition sets carry on carry-out of the most significant bit
// - rotate through carry loads carry with the bit shifted out
package asm_pkg;

  // =====================================================================
  // widths
  localparam int DATA_W = 8;
  localparam int PROD_W = 16;
  localparam int NIB_W = 4;

  // =====================================================================
  // unbanked addresses
  localparam logic [7:0] ADDR_FLAGS = 8'h04;
  localparam logic [7:0] ADDR_PROD_LO = 8'h18;
  localparam logic [7:0] ADDR_PROD_HI = 8'h19;

  // =====================================================================
  // flags register layout
  localparam int FLAG_C = 0;
  localparam int FLAG_DC = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_OV = 3;
  localparam int PTR0_LSB = 4;
  localparam int PTR1_LSB = 6;
  localparam int FLAGS_W = 4;

  // =====================================================================
  // reset values
  localparam logic [7:0] FLAGS_RST = 8'hF0;
  localparam logic [7:0] PROD_RST = 8'h00;
  localparam logic [7:0] WORKING_ACCUMULATOR_RST = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONES = 8'hFF;

  // =====================================================================
  // which low flags an operation updates {ov, z, dc, c}
  localparam logic [3:0] AFF_NONE = 4'h0;
  localparam logic [3:0] AFF_ARITH = 4'hF;
  localparam logic [3:0] AFF_ZERO = 4'h4;
  localparam logic [3:0] AFF_CARRY = 4'h1;
  localparam logic [3:0] AFF_ZDC_C = 4'h7;

  // =====================================================================
  // operations
  typedef enum logic [4:0] {
    OP_ADD  = 5'h00,
    OP_ADDC = 5'h01,
    OP_SUB  = 5'h02,
    OP_AND  = 5'h03,
    OP_IOR  = 5'h04,
    OP_XOR  = 5'h05,
    OP_MOVW = 5'h06,
    OP_MOVF = 5'h07,
    OP_CLR  = 5'h08,
    OP_BCLR = 5'h09,
    OP_BSET = 5'h0A,
    OP_SWAP = 5'h0B,
    OP_RRC  = 5'h0C,
    OP_RLC  = 5'h0D,
    OP_INC  = 5'h0E,
    OP_DEC  = 5'h0F,
    OP_COMP = 5'h10,
    OP_MUL  = 5'h11
  } asm_op_t;

  // operand a source
  typedef enum logic [1:0] {
    SRC_FILE = 2'h0,
    SRC_IMM  = 2'h1,
    SRC_WORKING_ACCUMULATOR = 2'h2
  } asm_src_t;

endpackage

// file: design/asm_mult.sv
// Purpose: unsigned W x W array multiplier, combinational
// Assumes: caller registers the product
// Notes: partial products summed in a generate chain
`timescale 1ns/10ps
module asm_mult #(
  parameter int W = 8
) (
  // operands
  input wire logic [W-1:0] a_i,
  input wire logic [W-1:0] b_i,
  // product
  output logic [2*W-1:0] p_o
);

  if (W < 2) begin : g_bad_w
    $error("asm_mult: W must be at least 2");
  end

  // =====================================================================
  // partial product accumulation
  logic [2*W-1:0] acc [W+1];

  assign acc[0] = '0;

  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_pp
      logic [2*W-1:0] pp;
      assign pp = b_i[gi] ? ({{W{1'b0}}, a_i} << gi) : '0;
      assign acc[gi+1] = acc[gi] + pp;
    end
  endgenerate

  assign p_o = acc[W];

endmodule

// file: design/asm_alu_top.sv
// Purpose: 8-bit ALU with flags register, working accumulator and 8x8 multiplier
// Assumes: execution unit issues one op per enabled cycle with operands ready
// Notes: flags and product registers live here; other file writes are passed out
`timescale 1ns/10ps
module asm_alu_top
  import asm_pkg::*;
#(
  parameter int DW = DATA_W
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // operation issue
  input wire logic op_valid_i,
  input wire logic [4:0] op_code_i,
  input wire logic [1:0] src_sel_i,
  input wire logic [7:0] src_addr_i,
  input wire logic [7:0] file_data_i,
  input wire logic [7:0] imm_i,
  input wire logic [2:0] bit_idx_i,
  input wire logic dest_working_accumulator_i,
  input wire logic [7:0] dest_addr_i,
  // register read port
  input wire logic [7:0] rd_addr_i,
  output logic [7:0] rd_data_o,
  // file write toward the rest of data memory
  output logic file_we_o,
  output logic [7:0] file_addr_o,
  output logic [7:0] file_wdata_o,
  // state views
  output logic [7:0] working_accumulator_o,
  output logic [7:0] arith_flags_register_o,
  output logic [1:0] pointer_zero_mode_o,
  output logic [1:0] pointer_one_mode_o,
  output logic [7:0] multiply_result_low_o,
  output logic [7:0] multiply_result_high_o
);

  if (DW != DATA_W) begin : g_bad_dw
    $error("asm_alu_top: only an 8-bit datapath is supported");
  end

  // =====================================================================
  // state
  logic [7:0] working_accumulator_reg;
  logic [7:0] flags_reg;
  logic [7:0] prod_lo_reg;
  logic [7:0] prod_hi_reg;
  logic [7:0] rd_data_reg;
  logic file_we_reg;
  logic [7:0] file_addr_reg;
  logic [7:0] file_wdata_reg;

  // =====================================================================
  // operand selection
  asm_op_t op;
  logic fire;
  logic [7:0] file_val;
  logic [7:0] opa;

  assign op = asm_op_t'(op_code_i);
  assign fire = ce_i & op_valid_i;

  // owned registers are read from here, not from data memory
  always_comb begin
    unique case (src_addr_i)
      ADDR_FLAGS: file_val = flags_reg;
      ADDR_PROD_LO: file_val = prod_lo_reg;
      ADDR_PROD_HI: file_val = prod_hi_reg;
      default: file_val = file_data_i;
    endcase
  end

  // two-operand ops pair opa with the accumulator
  always_comb begin
    unique case (asm_src_t'(src_sel_i))
      SRC_IMM: opa = imm_i;
      SRC_WORKING_ACCUMULATOR: opa = working_accumulator_reg;
      default: opa = file_val;
    endcase
  end

  // =====================================================================
  // adder shared by add, add with carry, subtract, increment, decrement
  logic [7:0] add_y;
  logic add_cin;
  logic [8:0] add_sum;
  logic [4:0] add_nib;
  logic add_ov;

  always_comb begin
    add_y = working_accumulator_reg;
    add_cin = 1'b0;
    unique case (op)
      OP_ADDC: add_cin = flags_reg[FLAG_C];
      OP_SUB: begin
        // a - w as a + ~w + 1: carry out means no borrow
        add_y = ~working_accumulator_reg;
        add_cin = 1'b1;
      end
      OP_INC: begin
        add_y = BYTE_ZERO;
        add_cin = 1'b1;
      end
      OP_DEC: add_y = BYTE_ONES;
      default: add_y = working_accumulator_reg;
    endcase
  end

  assign add_sum = {1'b0, opa} + {1'b0, add_y} + {8'h00, add_cin};
  assign add_nib = {1'b0, opa[NIB_W-1:0]} + {1'b0, add_y[NIB_W-1:0]} + {4'h0, add_cin};
  // signs of operands agree and result sign differs
  assign add_ov = (opa[DW-1] == add_y[DW-1]) & (add_sum[DW-1] != opa[DW-1]);

  // =====================================================================
  // multiplier
  logic [15:0] product;

  asm_mult #(
    .W(DATA_W)
  ) u_mult (
    .a_i(opa),
    .b_i(working_accumulator_reg),
    .p_o(product)
  );

  // =====================================================================
  // result and flag outcome
  logic [7:0] res;
  logic [3:0] aff;
  logic [3:0] alu_flags;

  always_comb begin
    res = opa;
    aff = AFF_NONE;
    alu_flags = flags_reg[FLAGS_W-1:0];
    unique case (op)
      OP_ADD, OP_ADDC, OP_SUB: begin
        res = add_sum[DW-1:0];
        aff = AFF_ARITH;
        alu_flags[FLAG_C] = add_sum[DW];
        alu_flags[FLAG_DC] = add_nib[NIB_W];
        alu_flags[FLAG_OV] = add_ov;
      end
      OP_INC, OP_DEC: begin
        res = add_sum[DW-1:0];
        aff = AFF_ARITH;
        alu_flags[FLAG_C] = add_sum[DW];
        alu_flags[FLAG_DC] = add_nib[NIB_W];
        alu_flags[FLAG_OV] = add_ov;
      end
      OP_AND: begin
        res = opa & working_accumulator_reg;
        aff = AFF_ZERO;
      end
      OP_IOR: begin
        res = opa | working_accumulator_reg;
        aff = AFF_ZERO;
      end
      OP_XOR: begin
        res = opa ^ working_accumulator_reg;
        aff = AFF_ZERO;
      end
      OP_MOVF: aff = AFF_ZERO;
      OP_COMP: begin
        res = ~opa;
        aff = AFF_ZERO;
      end
      OP_CLR: begin
        res = BYTE_ZERO;
        aff = AFF_ZERO;
      end
      OP_MOVW: res = working_accumulator_reg;
      OP_BCLR: res = opa & ~(8'h01 << bit_idx_i);
      OP_BSET: res = opa | (8'h01 << bit_idx_i);
      OP_SWAP: res = {opa[NIB_W-1:0], opa[DW-1:NIB_W]};
      OP_RRC: begin
        res = {flags_reg[FLAG_C], opa[DW-1:1]};
        aff = AFF_CARRY;
        alu_flags[FLAG_C] = opa[0];
      end
      OP_RLC: begin
        res = {opa[DW-2:0], flags_reg[FLAG_C]};
        aff = AFF_CARRY;
        alu_flags[FLAG_C] = opa[DW-1];
      end
      OP_MUL: res = opa;
      default: res = opa;
    endcase
    alu_flags[FLAG_Z] = (res == BYTE_ZERO);
  end

  // =====================================================================
  // destination decode
  logic to_flags;
  logic to_lo;
  logic to_hi;
  logic to_ext;
  logic is_mul;

  assign is_mul = (op == OP_MUL);
  assign to_flags = fire & ~is_mul & ~dest_working_accumulator_i & (dest_addr_i == ADDR_FLAGS);
  assign to_lo = fire & ~is_mul & ~dest_working_accumulator_i & (dest_addr_i == ADDR_PROD_LO);
  assign to_hi = fire & ~is_mul & ~dest_working_accumulator_i & (dest_addr_i == ADDR_PROD_HI);
  assign to_ext = fire & ~is_mul & ~dest_working_accumulator_i & ~to_flags & ~to_lo & ~to_hi;

  // =====================================================================
  // flags register
  logic [7:0] flags_next;
  logic [3:0] merged;

  assign merged = (aff & alu_flags) | (~aff & flags_reg[FLAGS_W-1:0]);

  always_comb begin
    flags_next = flags_reg;
    if (to_flags) begin
      if (aff[FLAG_Z:FLAG_C] != 3'h0) begin
        // data write to the low flags blocked, ALU outcome wins
        flags_next = {res[DW-1:FLAGS_W], merged};
      end else begin
        // plain file-register write, bit ops and stores included
        flags_next = res;
      end
    end else if (fire) begin
      flags_next = {flags_reg[DW-1:FLAGS_W], merged};
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      flags_reg <= FLAGS_RST;
    end else if (ce_i) begin
      flags_reg <= flags_next;
    end
  end

  // =====================================================================
  // working accumulator
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      working_accumulator_reg <= WORKING_ACCUMULATOR_RST;
    end else if (fire && !is_mul && dest_working_accumulator_i) begin
      working_accumulator_reg <= res;
    end
  end

  // =====================================================================
  // product registers
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      prod_lo_reg <= PROD_RST;
      prod_hi_reg <= PROD_RST;
    end else if (fire && is_mul) begin
      prod_lo_reg <= product[DW-1:0];
      prod_hi_reg <= product[PROD_W-1:DW];
    end else begin
      if (to_lo) begin
        prod_lo_reg <= res;
      end
      if (to_hi) begin
        prod_hi_reg <= res;
      end
    end
  end

  // =====================================================================
  // external file write
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      file_we_reg <= 1'b0;
      file_addr_reg <= BYTE_ZERO;
      file_wdata_reg <= BYTE_ZERO;
    end else if (ce_i) begin
      file_we_reg <= to_ext;
      if (to_ext) begin
        file_addr_reg <= dest_addr_i;
        file_wdata_reg <= res;
      end
    end
  end

  // =====================================================================
  // register read port, unowned addresses read zero
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      rd_data_reg <= BYTE_ZERO;
    end else if (ce_i) begin
      unique case (rd_addr_i)
        ADDR_FLAGS: rd_data_reg <= flags_reg;
        ADDR_PROD_LO: rd_data_reg <= prod_lo_reg;
        ADDR_PROD_HI: rd_data_reg <= prod_hi_reg;
        default: rd_data_reg <= BYTE_ZERO;
      endcase
    end
  end

  // =====================================================================
  // outputs
  assign rd_data_o = rd_data_reg;
  assign file_we_o = file_we_reg;
  assign file_addr_o = file_addr_reg;
  assign file_wdata_o = file_wdata_reg;
  assign working_accumulator_o = working_accumulator_reg;
  assign arith_flags_register_o = flags_reg;
  assign pointer_zero_mode_o = flags_reg[PTR0_LSB+1:PTR0_LSB];
  assign pointer_one_mode_o = flags_reg[PTR1_LSB+1:PTR1_LSB];
  assign multiply_result_low_o = prod_lo_reg;
  assign multiply_result_high_o = prod_hi_reg;

endmodule

// file: sim/asm_exec_model.sv
// Purpose: execution-unit side model that feeds file operands and takes write-backs
// Assumes: a write lands on the edge at which the write pulse is seen
// Notes: addresses owned by the alu return a moving pattern
`timescale 1ns/10ps
module asm_exec_model
  import asm_pkg::*;
(
  // clock
  input wire logic mclk_i,
  // operand fetch
  input wire logic [7:0] src_addr_i,
  output logic [7:0] file_data_o,
  // write-back
  input wire logic file_we_i,
  input wire logic [7:0] file_addr_i,
  input wire logic [7:0] file_wdata_i
);
  logic [7:0] mem [256];
  logic [7:0] pat_reg = 8'hA5;
  initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
  always @(posedge mclk_i) begin
    pat_reg <= pat_reg + 8'h3B;
    if (file_we_i) mem[file_addr_i] <= file_wdata_i;
  end
  // owned places are read inside the alu, so a wrong operand mux sees junk
  // a write still on its way to memory is forwarded, as the core's bypass does
  assign file_data_o = (file_we_i && file_addr_i == src_addr_i) ? file_wdata_i :
    src_addr_i inside {ADDR_FLAGS, ADDR_PROD_LO, ADDR_PROD_HI} ?
    pat_reg : mem[src_addr_i];
endmodule

// file: sim/asm_alu_top_asserts.sv
// Purpose: port-level checks of the alu, its flags register and multiplier
// Assumes: one clock, synchronous active-low reset
// Notes: immediate operands give exact expected results
`timescale 1ns/10ps
module asm_alu_top_asserts
  import asm_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  // issue
  input wire logic ce_i,
  input wire logic op_valid_i,
  input wire logic [4:0] op_code_i,
  input wire logic [1:0] src_sel_i,
  input wire logic [7:0] imm_i,
  input wire logic dest_working_accumulator_i,
  input wire logic [7:0] dest_addr_i,
  // results
  input wire logic file_we_o,
  input wire logic [7:0] working_accumulator_o,
  input wire logic [7:0] arith_flags_register_o,
  input wire logic [7:0] multiply_result_low_o,
  input wire logic [7:0] multiply_result_high_o
);
  wire [7:0] acc = working_accumulator_o;
  wire [7:0] fl = arith_flags_register_o;
  wire [8:0] s9 = {1'h0, imm_i} + {1'h0, acc};
  wire [4:0] h5 = {1'h0, imm_i[3:0]} + {1'h0, acc[3:0]};
  wire [3:0] add_fl = {imm_i[7] == acc[7] && s9[7] != acc[7], s9[7:0] == 8'h00, h5[4], s9[8]};
  wire [11:0] add_q = {add_fl, s9[7:0]};
  wire [7:0] fl_exp = {s9[7:4], add_fl};
  wire c_now = fl[0];
  wire own = dest_addr_i inside {ADDR_FLAGS, ADDR_PROD_LO, ADDR_PROD_HI};
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  // =====================================================================
  // issue sequences
  sequence s_go(logic [4:0] code);
    ce_i && op_valid_i && op_code_i == code;
  endsequence
  sequence s_imm(logic [4:0] code, logic to_w);
    s_go(code) ##0 (src_sel_i == SRC_IMM && dest_working_accumulator_i == to_w);
  endsequence
  // =====================================================================
  // properties
  property p_rst;
    disable iff (1'h0) !nrst_i |=> fl == FLAGS_RST && acc == WORKING_ACCUMULATOR_RST;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_clr;
    s_go(OP_CLR) ##0 (!dest_working_accumulator_i && dest_addr_i == ADDR_FLAGS) |=>
      (fl & 8'hFB) == ($past(fl) & 8'h0B) && fl[2];
  endproperty
  a_clr: assert property (p_clr) else $error("clear of flags wrong");
  property p_add;
    s_imm(OP_ADD, 1'h1) |=> {fl[3:0], acc} == $past(add_q);
  endproperty
  a_add: assert property (p_add) else $error("add result wrong");
  property p_dst;
    s_imm(OP_ADD, 1'h0) ##0 dest_addr_i == ADDR_FLAGS |=> fl == $past(fl_exp);
  endproperty
  a_dst: assert property (p_dst) else $error("flags as destination wrong");
  property p_sub;
    s_imm(OP_SUB, 1'h1) |=> fl[0] == ($past(imm_i) >= $past(acc));
  endproperty
  a_sub: assert property (p_sub) else $error("borrow wrong");
  property p_mul;
    s_go(OP_MUL) ##0 src_sel_i == SRC_IMM |=>
      {multiply_result_high_o, multiply_result_low_o} == $past(imm_i) * $past(acc);
  endproperty
  a_mul: assert property (p_mul) else $error("product wrong");
  property p_rrc;
    s_go(OP_RRC) ##0 (src_sel_i == SRC_WORKING_ACCUMULATOR && dest_working_accumulator_i) |=>
      {acc, fl[0]} == {$past(c_now), $past(acc)};
  endproperty
  a_rrc: assert property (p_rrc) else $error("rotate wrong");
  property p_we;
    s_go(OP_MOVW) ##0 (!dest_working_accumulator_i && !own) |=> file_we_o;
  endproperty
  a_we: assert property (p_we) else $error("file write missing");
endmodule

bind asm_alu_top asm_alu_top_asserts u_chk (.*);

// file: sim/test_alu_status_and_multiplier.sv
// Purpose: self-checking bench for the alu, flags register and multiplier
// Assumes: partner model supplies file operands
// Notes: random ops from a fixed seed with corner cases first
`timescale 1ns/10ps
module test_alu_status_and_multiplier;
  import asm_pkg::*;
  typedef struct packed {logic [3:0] aff; logic [3:0] fl; logic [7:0] r;} asm_res_t;
  localparam logic ON = 1'h1;
  localparam logic OFF = 1'h0;
  logic mclk_i = 1'h0, nrst_i = 1'h0, ce_i = 1'h0, op_valid_i = 1'h0, dest_working_accumulator_i = 1'h0;
  logic [4:0] op_code_i = 5'h00;
  logic [1:0] src_sel_i = 2'h0;
  logic [2:0] bit_idx_i = 3'h0;
  logic [7:0] src_addr_i = 8'h00, imm_i = 8'h00, dest_addr_i = 8'h00, rd_addr_i = 8'h00;
  logic [7:0] file_data_i, rd_data_o, file_addr_o, file_wdata_o, working_accumulator_o;
  logic [7:0] arith_flags_register_o, multiply_result_low_o, multiply_result_high_o;
  logic [1:0] pointer_zero_mode_o, pointer_one_mode_o;
  logic file_we_o, we;
  logic [7:0] w, f, pl, ph, rd, fa, fd;
  logic [7:0] mem [256];
  logic [7:0] ads [4] = '{ADDR_FLAGS, ADDR_PROD_LO, ADDR_PROD_HI, 8'h3C};
  integer seed = 32'h25F6;
  integer miscompares = 0;
  integer n_tests = 0;
  always #5 mclk_i = ~mclk_i;
  asm_alu_top u_dut (.*);
  asm_exec_model u_exec (.mclk_i(mclk_i), .src_addr_i(src_addr_i), .file_data_o(file_data_i),
    .file_we_i(file_we_o), .file_addr_i(file_addr_o), .file_wdata_i(file_wdata_o));
  // =====================================================================
  // expectations
  function automatic asm_res_t calc(logic [4:0] op, logic [7:0] a, b, logic c, logic [2:0] bi);
    logic [8:0] s;
    logic [4:0] h;
    logic ci;
    asm_res_t q;
    ci = op == OP_ADDC ? c : (op == OP_SUB || op == OP_INC);
    b = op == OP_SUB ? ~b : op == OP_INC ? 8'h00 : op == OP_DEC ? 8'hFF : b;
    s = {1'h0, a} + {1'h0, b} + 9'(ci);
    h = {1'h0, a[3:0]} + {1'h0, b[3:0]} + 5'(ci);
    q.aff = AFF_ZERO;
    case (op)
      OP_ADD, OP_ADDC, OP_SUB, OP_INC, OP_DEC: {q.aff, q.r} = {AFF_ARITH, s[7:0]};
      OP_AND: q.r = a & b;
      OP_IOR: q.r = a | b;
      OP_XOR: q.r = a ^ b;
      OP_MOVF: q.r = a;
      OP_COMP: q.r = ~a;
      OP_RRC: {q.aff, q.r, s[8]} = {AFF_CARRY, c, a};
      OP_RLC: {q.aff, s[8], q.r} = {AFF_CARRY, a, c};
      OP_BCLR: {q.aff, q.r} = {AFF_NONE, a & ~(8'h01 << bi)};
      OP_BSET: {q.aff, q.r} = {AFF_NONE, a | (8'h01 << bi)};
      OP_SWAP: {q.aff, q.r} = {AFF_NONE, a[3:0], a[7:4]};
      OP_MOVW: {q.aff, q.r} = {AFF_NONE, b};
      OP_MUL: {q.aff, q.r} = {AFF_NONE, 8'h00};
      default: q.r = 8'h00;
    endcase
    q.fl = {a[7] == b[7] && q.r[7] != a[7], q.r == 8'h00, h[4], s[8]};
    return q;
  endfunction
  function automatic logic [7:0] rv(logic [7:0] ad, dflt);
    case (ad)
      ADDR_FLAGS: return f;
      ADDR_PROD_LO: return pl;
      ADDR_PROD_HI: return ph;
      default: return dflt;
    endcase
  endfunction
  // =====================================================================
  // drive, predict, compare
  task chk(logic [7:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task rst;
    @(negedge mclk_i);
    {nrst_i, op_valid_i, ce_i} = 3'h0;
    repeat (4) @(negedge mclk_i);
    nrst_i = ON;
    {w, f, pl, ph, rd, we} = {WORKING_ACCUMULATOR_RST, FLAGS_RST, PROD_RST, PROD_RST, BYTE_ZERO, OFF};
  endtask
  task step(logic c, v, logic [4:0] op, logic [1:0] ss, logic [7:0] sa, im, logic dw,
    logic [7:0] da);
    asm_res_t q;
    logic [7:0] a;
    @(negedge mclk_i);
    {ce_i, op_valid_i, op_code_i, src_sel_i} = {c, v, op, ss};
    {src_addr_i, imm_i, dest_working_accumulator_i, dest_addr_i} = {sa, im, dw, da};
    bit_idx_i = 3'($random(seed));
    rd_addr_i = ads[2'($random(seed))];
    if (c) {rd, we} = {rv(rd_addr_i, 8'h00), OFF};
    if (c && v) begin
      a = ss == SRC_IMM ? im : ss == SRC_WORKING_ACCUMULATOR ? w : rv(sa, mem[sa]);
      q = calc(op, a, w, f[0], bit_idx_i);
      f[3:0] = (q.aff & q.fl) | (~q.aff & f[3:0]);
      if (op == OP_MUL) {ph, pl} = a * w;
      else if (dw) w = q.r;
      else if (da == ADDR_FLAGS) f = q.aff[2:0] == 3'h0 ? q.r : {q.r[7:4], f[3:0]};
      else if (da == ADDR_PROD_LO) pl = q.r;
      else if (da == ADDR_PROD_HI) ph = q.r;
      else {we, fa, fd, mem[da]} = {ON, da, q.r, q.r};
    end
    @(posedge mclk_i);
    #1;
    chk(working_accumulator_o, w);
    chk(arith_flags_register_o, f);
    chk({pointer_one_mode_o, pointer_zero_mode_o, 4'h0}, {f[7:4], 4'h0});
    chk(multiply_result_low_o, pl);
    chk(multiply_result_high_o, ph);
    chk(rd_data_o, rd);
    chk({7'h00, file_we_o}, {7'h00, we});
    if (we) chk(file_addr_o, fa);
    if (we) chk(file_wdata_o, fd);
  endtask
  task end_of_test;
    if (miscompares == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // =====================================================================
  // main sequence
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
    rst();
    step(ON, ON, OP_MOVF, SRC_IMM, 8'h00, 8'h01, ON, 8'h00);
    step(ON, ON, OP_ADD, SRC_IMM, 8'h00, 8'hFF, ON, 8'h00);
    step(ON, ON, OP_CLR, SRC_IMM, 8'h00, 8'h00, OFF, ADDR_FLAGS);
    step(ON, ON, OP_MOVF, SRC_IMM, 8'h00, 8'h7F, ON, 8'h00);
    step(ON, ON, OP_ADD, SRC_IMM, 8'h00, 8'h01, OFF, ADDR_FLAGS);
    step(ON, ON, OP_SUB, SRC_IMM, 8'h00, 8'h03, ON, 8'h00);
    step(ON, ON, OP_RRC, SRC_WORKING_ACCUMULATOR, 8'h00, 8'h00, ON, 8'h00);
    step(ON, ON, OP_RLC, SRC_FILE, 8'h3C, 8'h00, OFF, 8'h3C);
    step(ON, ON, OP_MOVW, SRC_FILE, 8'h3C, 8'h00, OFF, 8'h3C);
    step(ON, ON, OP_MOVF, SRC_IMM, 8'h00, 8'hFF, ON, 8'h00);
    step(ON, ON, OP_MUL, SRC_IMM, 8'h00, 8'hFF, ON, 8'h00);
    step(OFF, ON, OP_CLR, SRC_IMM, 8'h00, 8'h00, ON, 8'h00);
    for (int k = 0; k < 4; k++)
      step(ON, ON, k == 3 ? OP_MOVW : 5'(OP_BCLR + k), SRC_FILE, ADDR_FLAGS, 8'h00, OFF,
        ADDR_FLAGS);
    for (int k = 0; k < 400; k++) begin
      if (k == 200) rst();
      step(3'($random(seed)) != 3'h0, 3'($random(seed)) != 3'h0,
        5'($unsigned($random(seed)) % 18), 2'($unsigned($random(seed)) % 3),
        ads[2'($random(seed))], 8'($random(seed)), 1'($random(seed)), ads[2'($random(seed))]);
    end
    end_of_test();
  end
  initial begin
    repeat (3000) @(posedge mclk_i);
    miscompares++;
    end_of_test();
  end
endmodule
